// file: dv/test_mfl_fault_cfg.sv
// self-checking bench for the fault response configuration block
`timescale 1ns/100ps
module test_mfl_fault_cfg;
	// ------------------------------------------------------------
	// stimulus and observed signals
	// ------------------------------------------------------------
	// short millisecond so the filter tests stay brief
	localparam int MS = 5;
	logic        MCLK             = 1'b0;
	logic        RSTN             = 1'b0;
	logic [9:0]  ADDRESS          = 10'h000;
	logic        READ             = 1'b0;
	logic        WRITE            = 1'b0;
	logic [31:0] WRITEDATA        = 32'h0000_0000;
	logic [3:0]  BYTEENABLE       = 4'hf;
	logic        PHASE_SENSE_OVER = 1'b0;
	logic        NO_MOTOR_IN      = 1'b0;
	logic        PWM_CYCLE_START  = 1'b0;
	logic        HS_MOD           = 1'b0;
	logic [31:0] READDATA;
	logic        WAITREQUEST;
	logic        RECIRC;
	logic        FAULT_OUT_N;
	logic        NO_MOTOR_DET;
	logic [10:0] LOCK_LIMIT_MV;
	logic [20:0] LOCK_LIMIT_MA;
	logic        IRQ;
	int          error_cnt = 0;
	int          checks    = 0;
	int          gain, code, g, i, s, n;
	logic [31:0] w;
	int          nm_ms [8] = '{1, 10, 25, 50, 100, 250, 500, 1000};

	mfl_fault_cfg #(.MS_CYCLES(MS)) dut_u (
		.MCLK(MCLK), .RSTN(RSTN), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
		.WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
		.WAITREQUEST(WAITREQUEST), .PHASE_SENSE_OVER(PHASE_SENSE_OVER),
		.NO_MOTOR_IN(NO_MOTOR_IN), .PWM_CYCLE_START(PWM_CYCLE_START), .HS_MOD(HS_MOD),
		.RECIRC(RECIRC), .FAULT_OUT_N(FAULT_OUT_N), .NO_MOTOR_DET(NO_MOTOR_DET),
		.LOCK_LIMIT_MV(LOCK_LIMIT_MV), .LOCK_LIMIT_MA(LOCK_LIMIT_MA), .IRQ(IRQ)
	);

	initial begin
		forever #10 MCLK = ~MCLK;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic cyc(input int c);
		repeat (c) @(posedge MCLK);
	endtask

	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask

	// one bus access; holds everything until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge MCLK);
		ADDRESS   <= {idx, 2'b00};
		WRITE     <= wr;
		READ      <= ~wr;
		WRITEDATA <= d;
		// no cycle limit here: only the watchdog ends a stuck access
		do begin
			@(posedge MCLK);
		end while (WAITREQUEST !== 1'b0);
		q = READDATA;
		READ  <= 1'b0;
		WRITE <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, idx, 32'h0000_0000, q);
		chk_word("register read", exp, q);
	endtask

	function automatic logic [31:0] cfg(input int nm, input int oc, input int lk, input int rt);
		return {2'b00, nm[2:0], oc[3:0], lk[3:0], 8'h00, rt[2:0], 8'h00};
	endfunction

	// pin is synchronised, so the pulse must span several clocks
	task automatic pwm();
		PWM_CYCLE_START <= 1'b1;
		cyc(4);
		PWM_CYCLE_START <= 1'b0;
		cyc(6);
	endtask

	// one overcurrent event under a mode, then recovery by pwm edges
	task automatic oc_run(input int m, input logic hs);
		logic act;
		logic hold;
		int   r;
		int   k;
		r    = $urandom % 4;
		act  = (m <= 5) && (hs || m < 2 || m > 3);
		hold = act && m != 2 && m != 3;
		HS_MOD <= hs;
		wr(mfl_pkg::CFG1_IDX, cfg(0, m, 1, r));
		PHASE_SENSE_OVER <= 1'b1;
		cyc(8);
		chk_bit("recirc", act, RECIRC);
		chk_bit("fault_n", !(act && m % 2 == 0), FAULT_OUT_N);
		chk_bit("irq", act, IRQ);
		PHASE_SENSE_OVER <= 1'b0;
		cyc(8);
		chk_bit("recirc held", hold, RECIRC);
		for (k = 0; k <= r; k++) begin
			pwm();
			chk_bit("recirc pwm", hold && m > 3 && k < r, RECIRC);
		end
		chk_bit("fault_n idle", 1'b1, FAULT_OUT_N);
		rd(mfl_pkg::STAT_IDX, {30'h0, (m == 6), act});
		wr(mfl_pkg::CLR_IDX, 32'h0000_0007);
		rd(mfl_pkg::STAT_IDX, 32'h0000_0000);
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge MCLK);
		error_cnt++;
		give_verdict();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h58d9));
		cyc(12);
		RSTN <= 1'b1;
		cyc(2);
		chk_bit("recirc reset", 1'b0, RECIRC);
		chk_bit("fault_n reset", 1'b1, FAULT_OUT_N);
		rd(mfl_pkg::CFG1_IDX, 32'h0000_0000);
		rd(mfl_pkg::GAIN_IDX, 32'h0000_03e8);
		rd(mfl_pkg::STAT_IDX, 32'h0000_0000);
		rd(mfl_pkg::EN_IDX, 32'h0000_0000);
		w = $urandom;
		wr(mfl_pkg::CFG1_IDX, w);
		rd(mfl_pkg::CFG1_IDX, w & 32'hbfff_ff7f);
		wr(8'hff, 32'hffff_ffff);
		rd(8'hff, 32'h0000_0000);
		// lock limit at reset gain, then at a random gain
		gain = 1000;
		for (g = 0; g < 2; g++) begin
			if (g == 1) begin
				gain = 1 + $urandom % 65535;
				wr(mfl_pkg::GAIN_IDX, 32'(gain));
			end
			for (code = 0; code < 16; code++) begin
				// a division already running must finish before the new one starts
				wr(mfl_pkg::CFG1_IDX, cfg(0, 7, code, 0));
				cyc(60);
				n = (code == 0) ? 0 : code * 100000 / gain;
				chk_word("lock mv", 32'(code * 100), {21'h0, LOCK_LIMIT_MV});
				chk_word("lock ma", 32'(n), {11'h0, LOCK_LIMIT_MA});
			end
		end
		rd(mfl_pkg::LIMIT_IDX, {n[20:0], 11'h5dc});
		// every reaction code, then the below-limit codes without high side
		wr(mfl_pkg::EN_IDX, 32'h0000_0001);
		for (i = 0; i < 18; i++) begin
			oc_run((i < 16) ? i : i - 14, i < 16);
		end
		// no-motor filter times, upper bound for all, lower bound from the 10 ms code up
		for (s = 0; s < 8; s++) begin
			n = nm_ms[s] * MS;
			wr(mfl_pkg::CFG1_IDX, cfg(s, 7, 1, 0));
			NO_MOTOR_IN <= 1'b1;
			if (s > 0) begin
				cyc(n - MS - 2);
				chk_bit("no motor early", 1'b0, NO_MOTOR_DET);
				cyc(MS + 12);
			end else begin
				cyc(MS + 10);
			end
			chk_bit("no motor det", 1'b1, NO_MOTOR_DET);
			NO_MOTOR_IN <= 1'b0;
			cyc(2 * MS);
		end
		rd(mfl_pkg::STAT_IDX, 32'h0000_0004);
		chk_bit("irq masked", 1'b0, IRQ);
		wr(mfl_pkg::EN_IDX, 32'h0000_0004);
		cyc(3);
		chk_bit("irq enabled", 1'b1, IRQ);
		wr(mfl_pkg::CLR_IDX, 32'h0000_0004);
		cyc(3);
		chk_bit("irq cleared", 1'b0, IRQ);
		give_verdict();
	end
endmodule

// file: inc/mfl_pkg.sv
// constants and types for the motor fault limit configuration block
package mfl_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int           ADDR_W     = 10;
	localparam logic [7:0]   CFG1_IDX   = 8'h92;
	localparam logic [7:0]   STAT_IDX   = 8'ha0;
	localparam logic [7:0]   CLR_IDX    = 8'ha1;
	localparam logic [7:0]   EN_IDX     = 8'ha2;
	localparam logic [7:0]   GAIN_IDX   = 8'ha3;
	localparam logic [7:0]   LIMIT_IDX  = 8'ha4;
	localparam logic [31:0]  CFG1_RESET = 32'h0000_0000;
	localparam logic [31:0]  CFG1_WMASK = 32'hbfff_ff7f;
	localparam logic [15:0]  GAIN_RESET = 16'h03e8;
	localparam logic [2:0]   STAT_RESET = 3'h0;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PARITY_BIT = 31;
	localparam int RSVD_BIT   = 30;
	localparam int NM_LSB     = 27;
	localparam int OC_LSB     = 23;
	localparam int LK_LSB     = 19;
	localparam int RETRY_LSB  = 8;
	localparam int ST_OC      = 0;
	localparam int ST_REPORT  = 1;
	localparam int ST_NOMOTOR = 2;
	localparam int ST_W       = 3;
	// ------------------------------------------------------------
	// overcurrent reaction codes
	// ------------------------------------------------------------
	localparam logic [3:0] OC_NEXT_F  = 4'h0;
	localparam logic [3:0] OC_NEXT    = 4'h1;
	localparam logic [3:0] OC_BELOW_F = 4'h2;
	localparam logic [3:0] OC_BELOW   = 4'h3;
	localparam logic [3:0] OC_RETRY_F = 4'h4;
	localparam logic [3:0] OC_RETRY   = 4'h5;
	localparam logic [3:0] OC_REPORT  = 4'h6;
	// ------------------------------------------------------------
	// timing and scaling
	// ------------------------------------------------------------
	localparam int          CLK_HZ      = 50_000_000;
	localparam int          MS_PER_S    = 1000;
	localparam int          MS_CYCLES   = CLK_HZ / MS_PER_S;
	localparam logic [10:0] MV_PER_STEP = 11'h064;
	localparam logic [20:0] MA_PER_A    = 21'h0003e8;
	localparam int          DIV_W       = 21;
	localparam logic [9:0]  NM_MS [8]   = '{10'h001, 10'h00a, 10'h019, 10'h032,
	                                        10'h064, 10'h0fa, 10'h1f4, 10'h3e8};
	typedef enum logic [1:0] {S_IDLE, S_PWM, S_LOW, S_RETRY} mfl_oc_e;
endpackage

// file: rtl/mfl_div.sv
// serial restoring divider for the lock current threshold
`timescale 1ns/100ps
module mfl_div #(
	parameter int W = 21
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         start,
	input  wire logic [W-1:0] dividend,
	input  wire logic [W-1:0] divisor,
	output logic [W-1:0]      quot_r,
	output logic              busy_r,
	output logic              done_r
);
	logic [W-1:0] rem_r;
	logic [W-1:0] dv_r;
	logic [W-1:0] dd_r;
	logic [5:0]   cnt_r;
	logic [W:0]   sh;
	logic [W:0]   df;

	always_comb begin
		sh = {rem_r, quot_r[W-1]};
		df = sh - {1'b0, dv_r};
	end

	// ------------------------------------------------------------
	// one quotient bit per cycle
	// ------------------------------------------------------------
	// a zero divisor saturates the quotient to all ones
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			quot_r <= '0;
			rem_r  <= '0;
			dv_r   <= '0;
			dd_r   <= '0;
			cnt_r  <= 6'h00;
		end else begin
			done_r <= 1'b0;
			if (start && !busy_r) begin
				busy_r <= 1'b1;
				quot_r <= dividend;
				dd_r   <= dividend;
				dv_r   <= divisor;
				rem_r  <= '0;
				cnt_r  <= 6'(W);
			end else if (busy_r) begin
				if (!df[W]) begin
					rem_r  <= df[W-1:0]; // RQ9
					quot_r <= {quot_r[W-2:0], 1'b1};
				end else begin
					rem_r  <= sh[W-1:0];
					quot_r <= {quot_r[W-2:0], 1'b0};
				end
				cnt_r <= cnt_r - 6'h01;
				if (cnt_r == 6'h01) begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end
			end
		end
	end

	property p_div;
		@(posedge clk) disable iff (!rst_n)
		(done_r && dv_r != '0) |-> ({{W{1'b0}}, quot_r} * {{W{1'b0}}, dv_r}
			+ {{W{1'b0}}, rem_r} == {{W{1'b0}}, dd_r}) && rem_r < dv_r;
	endproperty
	a_div: assert property (p_div) else $error("threshold current quotient wrong"); // RQ9
endmodule

// file: rtl/mfl_fault_cfg.sv
// fault response configuration register and overcurrent reaction logic
//
// How it works
// (RQ1) no-motor filter time from 3-bit code
// (RQ2) codes 0/1 recirculate, resume next PWM
// (RQ3) codes 2/3 resume once phase voltage low
// (RQ4) below-limit codes only with high-side modulation
// (RQ5) codes 4/5 resume after retry PWM cycles
// (RQ6) code 6 reports only, bridge untouched
// (RQ7) codes 7 to F disable current limiting
// (RQ8) lock threshold 0.1 V steps from code
// (RQ9) lock current is threshold over amp gain
// (RQ10) parity bit stored, reserved bit reads zero
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/100ps
module mfl_fault_cfg #(
	parameter int MS_CYCLES = mfl_pkg::MS_CYCLES
) (
	input  wire logic                       MCLK,
	input  wire logic                       RSTN,
	input  wire logic [mfl_pkg::ADDR_W-1:0] ADDRESS,
	input  wire logic                       READ,
	input  wire logic                       WRITE,
	input  wire logic [31:0]                WRITEDATA,
	input  wire logic [3:0]                 BYTEENABLE,
	output logic      [31:0]                READDATA,
	output logic                            WAITREQUEST,
	input  wire logic                       PHASE_SENSE_OVER,
	input  wire logic                       NO_MOTOR_IN,
	input  wire logic                       PWM_CYCLE_START,
	input  wire logic                       HS_MOD,
	output logic                            RECIRC,
	output logic                            FAULT_OUT_N,
	output logic                            NO_MOTOR_DET,
	output logic      [10:0]                LOCK_LIMIT_MV,
	output logic      [20:0]                LOCK_LIMIT_MA,
	output logic                            IRQ
);
	localparam logic [mfl_pkg::ADDR_W-1:0] A_CFG1  = {mfl_pkg::CFG1_IDX, 2'b00};
	localparam logic [mfl_pkg::ADDR_W-1:0] A_STAT  = {mfl_pkg::STAT_IDX, 2'b00};
	localparam logic [mfl_pkg::ADDR_W-1:0] A_CLR   = {mfl_pkg::CLR_IDX, 2'b00};
	localparam logic [mfl_pkg::ADDR_W-1:0] A_EN    = {mfl_pkg::EN_IDX, 2'b00};
	localparam logic [mfl_pkg::ADDR_W-1:0] A_GAIN  = {mfl_pkg::GAIN_IDX, 2'b00};
	localparam logic [mfl_pkg::ADDR_W-1:0] A_LIMIT = {mfl_pkg::LIMIT_IDX, 2'b00};
	localparam int                         MSC_W   = $clog2(MS_CYCLES);

	logic [31:0]            cfg1_r;
	logic [15:0]            gain_r;
	logic [mfl_pkg::ST_W-1:0] status_r;
	logic [mfl_pkg::ST_W-1:0] enable_r;
	logic [mfl_pkg::ST_W-1:0] set_ev;
	logic [mfl_pkg::ST_W-1:0] clr_ev;
	logic [31:0]            be_mask;
	logic                   ack;
	logic                   wr_ack;
	logic [2:0]             s1_r;
	logic [2:0]             s2_r;
	logic                   pwm_d_r;
	logic                   oc_s;
	logic                   nm_s;
	logic                   pwm_edge;
	logic [MSC_W-1:0]       msc_r;
	logic                   ms_tick_r;
	logic                   nm_det_d_r;
	mfl_pkg::mfl_oc_e       st_r;
	logic [3:0]             mode_r;
	logic [2:0]             rcnt_r;
	logic [3:0]             oc_mode;
	logic [2:0]             retry;
	logic [3:0]             lk;
	logic                   act;
	logic [3:0]             lk_prev_r;
	logic [15:0]            gain_prev_r;
	logic                   div_start;
	logic                   div_busy;
	logic                   div_done;
	logic [20:0]            div_q;

	assign oc_mode = cfg1_r[mfl_pkg::OC_LSB +: 4];
	assign retry   = cfg1_r[mfl_pkg::RETRY_LSB +: 3];
	assign lk      = cfg1_r[mfl_pkg::LK_LSB +: 4];
	assign be_mask = {{8{BYTEENABLE[3]}}, {8{BYTEENABLE[2]}},
	                  {8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge MCLK) begin
				if (!RSTN) begin
					s1_r[gi] <= 1'b0;
					s2_r[gi] <= 1'b0;
				end else begin
					s1_r[gi] <= (gi == 0) ? PHASE_SENSE_OVER :
					            (gi == 1) ? NO_MOTOR_IN : PWM_CYCLE_START;
					s2_r[gi] <= s1_r[gi];
				end
			end
		end
	endgenerate

	assign oc_s     = s2_r[0];
	assign nm_s     = s2_r[1];
	assign pwm_edge = s2_r[2] & ~pwm_d_r;

	always_ff @(posedge MCLK) begin
		if (!RSTN)
			pwm_d_r <= 1'b0;
		else
			pwm_d_r <= s2_r[2];
	end

	// ------------------------------------------------------------
	// avalon slave, one wait state per access
	// ------------------------------------------------------------
	assign ack    = (READ | WRITE) & ~WAITREQUEST;
	assign wr_ack = WRITE & ~WAITREQUEST;

	always_ff @(posedge MCLK) begin
		if (!RSTN)
			WAITREQUEST <= 1'b1;
		else if ((READ | WRITE) && WAITREQUEST)
			WAITREQUEST <= 1'b0;
		else
			WAITREQUEST <= 1'b1;
	end

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			READDATA <= 32'h0000_0000;
		end else if (READ && WAITREQUEST) begin
			case (ADDRESS)
				A_CFG1:  READDATA <= cfg1_r; // RQ10
				A_STAT:  READDATA <= {29'h0, status_r};
				A_EN:    READDATA <= {29'h0, enable_r};
				A_GAIN:  READDATA <= {16'h0000, gain_r};
				A_LIMIT: READDATA <= {LOCK_LIMIT_MA, LOCK_LIMIT_MV};
				default: READDATA <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	// reserved bit 30 and bit 7 never leave reset through the write mask
	always_ff @(posedge MCLK) begin
		if (!RSTN)
			cfg1_r <= mfl_pkg::CFG1_RESET;
		else if (wr_ack && ADDRESS == A_CFG1)
			cfg1_r <= (cfg1_r & ~(be_mask & mfl_pkg::CFG1_WMASK))
			        | (WRITEDATA & be_mask & mfl_pkg::CFG1_WMASK); // RQ10
	end

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			gain_r   <= mfl_pkg::GAIN_RESET;
			enable_r <= mfl_pkg::STAT_RESET;
		end else if (wr_ack) begin
			if (ADDRESS == A_GAIN)
				gain_r <= (gain_r & ~be_mask[15:0]) | (WRITEDATA[15:0] & be_mask[15:0]);
			if (ADDRESS == A_EN && BYTEENABLE[0])
				enable_r <= WRITEDATA[mfl_pkg::ST_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// sticky status and interrupt
	// ------------------------------------------------------------
	assign clr_ev = (wr_ack && ADDRESS == A_CLR && BYTEENABLE[0]) ?
	                WRITEDATA[mfl_pkg::ST_W-1:0] : 3'h0;

	// set beats clear in the same cycle so no event is lost
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			status_r <= mfl_pkg::STAT_RESET;
			IRQ      <= 1'b0;
		end else begin
			status_r <= (status_r & ~clr_ev) | set_ev;
			IRQ      <= |(status_r & enable_r);
		end
	end

	// ------------------------------------------------------------
	// millisecond tick and no-motor filter
	// ------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			msc_r     <= '0;
			ms_tick_r <= 1'b0;
		end else if (msc_r == MSC_W'(MS_CYCLES - 1)) begin
			msc_r     <= '0;
			ms_tick_r <= 1'b1;
		end else begin
			msc_r     <= msc_r + 1'b1;
			ms_tick_r <= 1'b0;
		end
	end

	mfl_nomotor_filt u_nm (
		.clk     (MCLK),
		.rst_n   (RSTN),
		.ms_tick (ms_tick_r),
		.level   (nm_s),
		.sel     (cfg1_r[mfl_pkg::NM_LSB +: 3]),
		.det_r   (NO_MOTOR_DET)
	);

	always_ff @(posedge MCLK) begin
		if (!RSTN)
			nm_det_d_r <= 1'b0;
		else
			nm_det_d_r <= NO_MOTOR_DET;
	end

	// ------------------------------------------------------------
	// cycle by cycle overcurrent reaction
	// ------------------------------------------------------------
	always_comb begin
		case (oc_mode)
			mfl_pkg::OC_NEXT_F, mfl_pkg::OC_NEXT:   act = 1'b1; // RQ2
			mfl_pkg::OC_BELOW_F, mfl_pkg::OC_BELOW: act = HS_MOD; // RQ4
			mfl_pkg::OC_RETRY_F, mfl_pkg::OC_RETRY: act = 1'b1; // RQ5
			default:                                act = 1'b0; // RQ7
		endcase
	end

	assign set_ev[mfl_pkg::ST_OC]      = (st_r == mfl_pkg::S_IDLE) && oc_s && act;
	assign set_ev[mfl_pkg::ST_REPORT]  = oc_s && oc_mode == mfl_pkg::OC_REPORT; // RQ6
	assign set_ev[mfl_pkg::ST_NOMOTOR] = NO_MOTOR_DET && !nm_det_d_r;

	// mode is latched on entry so a rewrite cannot strand the bridge
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			st_r   <= mfl_pkg::S_IDLE;
			mode_r <= 4'h0;
			rcnt_r <= 3'h0;
		end else begin
			case (st_r)
				mfl_pkg::S_IDLE: begin
					if (oc_s && act) begin
						mode_r <= oc_mode;
						rcnt_r <= 3'h0;
						case (oc_mode)
							mfl_pkg::OC_NEXT_F, mfl_pkg::OC_NEXT:
								st_r <= mfl_pkg::S_PWM; // RQ2
							mfl_pkg::OC_BELOW_F, mfl_pkg::OC_BELOW:
								st_r <= mfl_pkg::S_LOW; // RQ3
							default:
								st_r <= mfl_pkg::S_RETRY; // RQ5
						endcase
					end
				end
				mfl_pkg::S_PWM: begin
					if (pwm_edge)
						st_r <= mfl_pkg::S_IDLE; // RQ2
				end
				mfl_pkg::S_LOW: begin
					if (!oc_s)
						st_r <= mfl_pkg::S_IDLE; // RQ3
				end
				mfl_pkg::S_RETRY: begin
					if (pwm_edge) begin
						if (rcnt_r >= retry)
							st_r <= mfl_pkg::S_IDLE; // RQ5
						else
							rcnt_r <= rcnt_r + 3'h1;
					end
				end
				default: st_r <= mfl_pkg::S_IDLE;
			endcase
		end
	end

	// even codes 0, 2 and 4 pull the fault line while reacting, odd codes keep it quiet
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			RECIRC      <= 1'b0;
			FAULT_OUT_N <= 1'b1;
		end else begin
			RECIRC      <= (st_r != mfl_pkg::S_IDLE); // RQ2
			FAULT_OUT_N <= !((st_r != mfl_pkg::S_IDLE) && !mode_r[0]); // RQ3
		end
	end

	// ------------------------------------------------------------
	// lock detection threshold
	// ------------------------------------------------------------
	assign div_start = !div_busy && (lk != lk_prev_r || gain_r != gain_prev_r);

	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			LOCK_LIMIT_MV <= 11'h000;
			LOCK_LIMIT_MA <= 21'h000000;
			lk_prev_r     <= 4'h0;
			gain_prev_r   <= 16'h0000;
		end else begin
			LOCK_LIMIT_MV <= 11'(lk * mfl_pkg::MV_PER_STEP); // RQ8
			if (div_start) begin
				lk_prev_r   <= lk;
				gain_prev_r <= gain_r;
			end
			if (div_done)
				LOCK_LIMIT_MA <= (lk_prev_r == 4'h0) ? 21'h000000 : div_q; // RQ9
		end
	end

	mfl_div #(
		.W (mfl_pkg::DIV_W)
	) u_div (
		.clk      (MCLK),
		.rst_n    (RSTN),
		.start    (div_start),
		.dividend (21'(lk * mfl_pkg::MV_PER_STEP) * mfl_pkg::MA_PER_A),
		.divisor  ({5'h00, gain_r}),
		.quot_r   (div_q),
		.busy_r   (div_busy),
		.done_r   (div_done)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_resume;
		st_r == mfl_pkg::S_IDLE ##1 !RECIRC;
	endsequence

	property p_next_pwm;
		@(posedge MCLK) disable iff (!RSTN)
		(st_r == mfl_pkg::S_PWM && pwm_edge) |=> s_resume;
	endproperty
	a_next_pwm: assert property (p_next_pwm) else $error("no resume on PWM cycle"); // RQ2

	property p_fault_on;
		@(posedge MCLK) disable iff (!RSTN)
		(st_r != mfl_pkg::S_IDLE && !mode_r[0]) |=> !FAULT_OUT_N && RECIRC;
	endproperty
	a_fault_on: assert property (p_fault_on) else $error("fault line not pulled"); // RQ2

	property p_fault_off;
		@(posedge MCLK) disable iff (!RSTN)
		(st_r != mfl_pkg::S_IDLE && mode_r[0]) |=> FAULT_OUT_N;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("fault line pulled quietly"); // RQ3

	property p_below;
		@(posedge MCLK) disable iff (!RSTN)
		(st_r == mfl_pkg::S_LOW && oc_s) |=> st_r == mfl_pkg::S_LOW;
	endproperty
	a_below: assert property (p_below) else $error("resumed above limit"); // RQ3

	property p_hs_only;
		@(posedge MCLK) disable iff (!RSTN)
		(st_r == mfl_pkg::S_IDLE && oc_s && !HS_MOD && oc_mode[3:1] == 3'h1)
			|=> st_r == mfl_pkg::S_IDLE ##1 !RECIRC;
	endproperty
	a_hs_only: assert property (p_hs_only) else $error("below-limit mode without HS"); // RQ4

	property p_retry;
		@(posedge MCLK) disable iff (!RSTN)
		(st_r == mfl_pkg::S_RETRY && pwm_edge && rcnt_r < retry)
			|=> st_r == mfl_pkg::S_RETRY && rcnt_r == $past(rcnt_r) + 3'h1;
	endproperty
	a_retry: assert property (p_retry) else $error("retry count cut short"); // RQ5

	property p_report;
		@(posedge MCLK) disable iff (!RSTN)
		(st_r == mfl_pkg::S_IDLE && oc_s && oc_mode == mfl_pkg::OC_REPORT)
			|=> st_r == mfl_pkg::S_IDLE && status_r[mfl_pkg::ST_REPORT];
	endproperty
	a_report: assert property (p_report) else $error("report mode misbehaved"); // RQ6

	property p_disabled;
		@(posedge MCLK) disable iff (!RSTN)
		(st_r == mfl_pkg::S_IDLE && oc_mode >= 4'h7) |=> st_r == mfl_pkg::S_IDLE;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled limit acted"); // RQ7

	property p_lock_mv;
		@(posedge MCLK) disable iff (!RSTN)
		$stable(lk) |=> LOCK_LIMIT_MV == 11'($past(lk) * 11'h064);
	endproperty
	a_lock_mv: assert property (p_lock_mv) else $error("lock threshold voltage wrong"); // RQ8

	property p_rsvd;
		@(posedge MCLK) disable iff (!RSTN)
		(READ && !WAITREQUEST && $past(ADDRESS) == A_CFG1)
			|-> !READDATA[mfl_pkg::RSVD_BIT] && READDATA[31] == cfg1_r[31];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved or parity bit wrong"); // RQ10
endmodule

// file: rtl/mfl_nomotor_filt.sv
// no-motor detect deglitch filter counting millisecond ticks
`timescale 1ns/100ps
module mfl_nomotor_filt (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ms_tick,
	input  wire logic       level,
	input  wire logic [2:0] sel,
	output logic            det_r
);
	logic [9:0] cnt_r;
	logic [9:0] lim;

	assign lim = mfl_pkg::NM_MS[sel];

	// ------------------------------------------------------------
	// filter
	// ------------------------------------------------------------
	// tick phase is free running, so the held time is up to 1 ms short
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r <= 10'h000;
			det_r <= 1'b0;
		end else if (!level) begin
			cnt_r <= 10'h000;
			det_r <= 1'b0;
		end else begin
			if (ms_tick && cnt_r < lim)
				cnt_r <= cnt_r + 10'h001; // RQ1
			det_r <= (cnt_r >= lim); // RQ1
		end
	end

	property p_nm_det;
		@(posedge clk) disable iff (!rst_n)
		$rose(det_r) |-> $past(level, 1) && $past(cnt_r, 1) >= $past(lim, 1);
	endproperty
	a_nm_det: assert property (p_nm_det) else $error("no-motor detect without filter time"); // RQ1
endmodule
